// [hdl/twcs_ctrl_status.sv]
// apb register block holding control, status and buffers of the two-wire port
`timescale 1ns/10ps
// What this block does
// - module_enable hands the data and clock pins to the serial port.
// - idle_stop halts the module while the device is idle.
// - with stretching on, clock_release is read/write; hardware clears on slave tx/rx.
// - with stretching off, software may only set clock_release; slave tx clears it.
// - accept_all_addresses acknowledges every incoming address.
// - ten_bit_address_mode selects 10-bit or 7-bit slave address matching.
// - general call interrupt only when general_call_enable set and module enabled.
// - ack_sequence_go sends ack_value as acknowledge; cleared when sequence ends.
// - master_receive_go receives one byte; cleared after the eighth bit.
// - start, restart and stop requests cleared when their sequence completes.
// - ack_received_status takes the slave acknowledge bit at its end.
// - master_tx_active set at transmit start, cleared after slave acknowledge.
// - bus_collision set on collision; software may only clear it.
// - general_call_seen set on general call address, cleared on stop.
// - ten_bit_matched set on matching second address byte, cleared on stop.
// - transmit write while busy is dropped and sets tx_write_collision.
// - byte arriving with receive buffer full sets rx_overflow.
// - data_or_addr_flag cleared on address match, set on data byte.
// - start and stop flags show only the last detected condition.
// - read_write_dir takes the direction bit of the matched address.
// - rx_buffer_full set on buffer load, cleared when software reads it.
// - tx_buffer_full set on transmit write, cleared when transmission completes.
// - complete byte moves into receive buffer, when it is not full, and raises an interrupt pulse.
// - baud_reload supplies the reload value of the bus clock counter.
module twcs_ctrl_status #(
   parameter int BAUD_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial engine side
   input twcs_pkg::twcs_evt_t evt,
   input wire logic [7:0] rxByte,
   output twcs_pkg::twcs_ctl_t ctl,
   output logic [7:0] txData,
   output logic txFull,
   output logic [BAUD_W-1:0] baudReload,
   output logic [9:0] slaveAddr,
   // event pulses to the interrupt fabric and engine
   output logic addrAck,
   output logic genCallIrq,
   output logic rxIrq
);
   import twcs_pkg::*;

   // --------------------------------------------------------------------
   // registers
   // --------------------------------------------------------------------
   logic [15:0] ctrl_reg, ctrl_next;
   logic [31:0] rdata_reg;
   logic ready_reg, err_reg, run_reg;
   logic [7:0] txd_reg, rxd_reg;
   logic [9:0] saddr_reg;
   logic [BAUD_W-1:0] baud_reg;
   logic ack_received_status_reg, master_tx_active_reg, busColl_reg, general_call_seen_reg, tenMatch_reg, wrColl_reg;
   logic ov_reg, da_reg, stop_reg, start_reg, rw_reg, rxFull_reg, txFull_reg;
   logic hdrSeen_reg, addrAck_reg, gcIrq_reg, rxIrq_reg;

   // --------------------------------------------------------------------
   // apb decode
   // --------------------------------------------------------------------
   wire setupPh = psel & ~penable;
   wire accessPh = psel & penable & ready_reg;
   wire wrEn = accessPh & pwrite;
   wire rdEn = accessPh & ~pwrite;
   wire selCtrl = (paddr == CTRL_OFS);
   wire selStat = (paddr == STAT_OFS);
   wire selTxd = (paddr == TXD_OFS);
   wire selRxd = (paddr == RXD_OFS);
   wire selSaddr = (paddr == SADDR_OFS);
   wire selBaud = (paddr == BAUD_OFS);
   wire mapped = selCtrl | selStat | selTxd | selRxd | selSaddr | selBaud;
   wire ctrlWr = wrEn & selCtrl;
   wire statWr = wrEn & selStat;
   wire txWr = wrEn & selTxd;
   wire rxRd = rdEn & selRxd;

   wire [15:0] statVec = {ack_received_status_reg, master_tx_active_reg, 3'h0, busColl_reg, general_call_seen_reg,
                          tenMatch_reg, wrColl_reg, ov_reg, da_reg, stop_reg, start_reg,
                          rw_reg, rxFull_reg, txFull_reg};
   // read data is latched in the setup phase so the bus sees no wait state
   wire [31:0] rdMux = selCtrl ? {16'h0, ctrl_reg} :
                       selStat ? {16'h0, statVec} :
                       selTxd ? {24'h0, txd_reg} :
                       selRxd ? {24'h0, rxd_reg} :
                       selSaddr ? {22'h0, saddr_reg} :
                       selBaud ? {{(32 - BAUD_W){1'b0}}, baud_reg} : 32'h0;

   // --------------------------------------------------------------------
   // slave address matching
   // --------------------------------------------------------------------
   wire enOn = ctrl_reg[C_EN];
   wire tenBit = ctrl_reg[C_TENBIT];
   wire gcHit = evt.addrFirst & (rxByte == GC_ADDR) & ctrl_reg[C_GENCALL];
   wire hit7 = evt.addrFirst & ~tenBit & (rxByte[7:1] == saddr_reg[6:0]);
   wire hitHdr = evt.addrFirst & tenBit & (rxByte[7:3] == TENBIT_HDR)
                 & (rxByte[2:1] == saddr_reg[9:8]);
   wire hit2 = evt.addrSecond & tenBit & hdrSeen_reg & (rxByte == saddr_reg[7:0]);
   wire firstHit = evt.addrFirst & (ctrl_reg[C_IPMI] | hit7 | hitHdr | gcHit);
   wire matchAck = firstHit | hit2 | (evt.addrSecond & ctrl_reg[C_IPMI]);

   // --------------------------------------------------------------------
   // receive and transmit path decisions
   // --------------------------------------------------------------------
   wire rxLoad = evt.rxValid & ~rxFull_reg;
   wire rxOver = evt.rxValid & rxFull_reg;
   wire txTake = txWr & ~evt.busy;
   wire txColl = txWr & evt.busy;

   // clock_release: software release wins over a hardware hold in the same cycle
   // the stretch mode in force before the write decides whether a zero holds the clock
   wire swRel = ctrlWr & pwdata[C_CLKREL];
   wire swHold = ctrlWr & ~pwdata[C_CLKREL] & ctrl_reg[C_STRETCH];
   wire hwHold = evt.slvTxBegin | (evt.slvRxEnd & ctrl_reg[C_STRETCH]);

   // --------------------------------------------------------------------
   // control register next value
   // --------------------------------------------------------------------
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrlWr) begin
         ctrl_next = pwdata[15:0] & CTRL_MASK;
         ctrl_next[C_CLKREL] = ctrl_reg[C_CLKREL];
      end
      if (swRel) begin
         ctrl_next[C_CLKREL] = 1'b1;
      end else if (swHold | hwHold) begin
         ctrl_next[C_CLKREL] = 1'b0;
      end
   end

   // request bits clear themselves when the engine reports the sequence done;
   // a fresh write of one in that cycle starts a new request and is kept
   logic [C_REQ_N-1:0] reqNext;
   genvar gi;
   generate
      for (gi = 0; gi < C_REQ_N; gi++) begin : g_req
         assign reqNext[gi] = ctrlWr ? pwdata[gi] :
                              (ctrl_reg[gi] & ~evt.seqDone[gi]);
      end
   endgenerate

   // --------------------------------------------------------------------
   // apb answer and control storage
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ready_reg <= 1'b0;
         err_reg <= 1'b0;
         rdata_reg <= 32'h0;
         ctrl_reg <= CTRL_RST;
         run_reg <= 1'b0;
      end else begin
         ready_reg <= setupPh;
         err_reg <= setupPh & ~mapped;
         rdata_reg <= setupPh ? rdMux : 32'h0;
         ctrl_reg <= {ctrl_next[15:C_REQ_N], reqNext};
         run_reg <= ctrl_next[C_EN] & ~(ctrl_next[C_SIDL] & evt.idleMode);
      end
   end

   // address and baud reload registers, plain software storage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         saddr_reg <= 10'h0;
         baud_reg <= '0;
      end else begin
         if (wrEn & selSaddr) saddr_reg <= pwdata[9:0];
         if (wrEn & selBaud) baud_reg <= pwdata[BAUD_W-1:0];
      end
   end

   // --------------------------------------------------------------------
   // data buffers
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txd_reg <= 8'h0;
         rxd_reg <= 8'h0;
         txFull_reg <= 1'b0;
         rxFull_reg <= 1'b0;
      end else begin
         if (txTake) txd_reg <= pwdata[7:0];
         if (rxLoad) rxd_reg <= rxByte;
         txFull_reg <= txTake | (txFull_reg & ~evt.txDone);
         rxFull_reg <= rxLoad | (rxFull_reg & ~rxRd);
      end
   end

   // --------------------------------------------------------------------
   // clear-only error flags: hardware set wins over a software clear
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busColl_reg <= 1'b0;
         wrColl_reg <= 1'b0;
         ov_reg <= 1'b0;
      end else begin
         busColl_reg <= evt.collision | (busColl_reg & ~(statWr & ~pwdata[S_BUSCOL]));
         wrColl_reg <= txColl | (wrColl_reg & ~(statWr & ~pwdata[S_WRCOL]));
         ov_reg <= rxOver | (ov_reg & ~(statWr & ~pwdata[S_OV]));
      end
   end

   // --------------------------------------------------------------------
   // master transmit status
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_received_status_reg <= 1'b0;
         master_tx_active_reg <= 1'b0;
      end else begin
         if (evt.ackDone) ack_received_status_reg <= evt.ackBit;
         master_tx_active_reg <= evt.mtxBegin | (master_tx_active_reg & ~evt.ackDone);
      end
   end

   // --------------------------------------------------------------------
   // slave addressing status and bus condition flags
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         general_call_seen_reg <= 1'b0;
         tenMatch_reg <= 1'b0;
         da_reg <= 1'b0;
         rw_reg <= 1'b0;
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
         hdrSeen_reg <= 1'b0;
      end else begin
         general_call_seen_reg <= gcHit | (general_call_seen_reg & ~evt.stopSeen);
         tenMatch_reg <= hit2 | (tenMatch_reg & ~evt.stopSeen);
         if (matchAck) begin
            da_reg <= 1'b0;
         end else if (evt.rxValid & ~evt.rxIsAddr) begin
            da_reg <= 1'b1;
         end
         if (firstHit) rw_reg <= rxByte[0];
         if (evt.startSeen) begin
            start_reg <= 1'b1;
            stop_reg <= 1'b0;
         end else if (evt.stopSeen) begin
            start_reg <= 1'b0;
            stop_reg <= 1'b1;
         end
         // the header byte must be seen before the second byte can match
         if (evt.addrFirst | evt.stopSeen) hdrSeen_reg <= hitHdr;
      end
   end

   // --------------------------------------------------------------------
   // one-cycle event pulses
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addrAck_reg <= 1'b0;
         gcIrq_reg <= 1'b0;
         rxIrq_reg <= 1'b0;
      end else begin
         addrAck_reg <= matchAck & enOn;
         gcIrq_reg <= gcHit & enOn;
         rxIrq_reg <= rxLoad;
      end
   end

   // --------------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------------
   assign prdata = rdata_reg;
   assign pready = ready_reg;
   assign pslverr = err_reg;
   assign txData = txd_reg;
   assign txFull = txFull_reg;
   assign baudReload = baud_reg;
   assign slaveAddr = saddr_reg;
   assign addrAck = addrAck_reg;
   assign genCallIrq = gcIrq_reg;
   assign rxIrq = rxIrq_reg;
   // pins are owned whenever the enable bit is set
   assign ctl.pinsOwned = ctrl_reg[C_EN];
   assign ctl.run = run_reg;
   assign ctl.holdClockLow = ~ctrl_reg[C_CLKREL];
   assign ctl.slewOff = ctrl_reg[C_SLEW];
   assign ctl.smbusLevels = ctrl_reg[C_SMB];
   assign ctl.ackValue = ctrl_reg[C_ACKVAL];
   assign ctl.reqGo = ctrl_reg[C_REQ_N-1:0];

   // --------------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   a_rx_load: assert property (rxLoad |=> rxFull_reg && rxIrq && rxd_reg == $past(rxByte))
      else $error("receive byte not loaded");
   a_rx_overflow: assert property (rxOver |=> ov_reg && !rxIrq)
      else $error("overflow not flagged");
   a_tx_collide: assert property (txColl |=> wrColl_reg && txd_reg == $past(txd_reg))
      else $error("busy transmit write not refused");
   a_tx_done: assert property (evt.txDone && !txTake |=> !txFull)
      else $error("transmit full not cleared");
   a_last_cond: assert property (evt.startSeen |=> start_reg && !stop_reg)
      else $error("start flag wrong");
   a_clk_hold: assert property (evt.slvTxBegin && !swRel |=> ctl.holdClockLow)
      else $error("clock not held at slave transmit");
   a_start_done: assert property (evt.seqDone[C_STARTGO] && !ctrlWr
                                  |=> !ctl.reqGo[C_STARTGO])
      else $error("start request not cleared");
   a_coll_sticky: assert property (evt.collision |=> busColl_reg
                                   ##1 (busColl_reg || $past(statWr)))
      else $error("collision flag lost");
   a_dir_bit: assert property (firstHit |=> rw_reg == $past(rxByte[0]))
      else $error("direction bit wrong");
   a_tx_status: assert property (evt.ackDone && !evt.mtxBegin |=> !master_tx_active_reg
                                 && ack_received_status_reg == $past(evt.ackBit))
      else $error("ack status wrong");

   a_tx_take: assert property (txTake |=> txFull && txData == $past(pwdata[7:0]))
      else $error("transmit write not taken");
   a_gc_seen: assert property (gcHit |=> general_call_seen_reg)
      else $error("general call not flagged");
   a_ten_match: assert property (hit2 |=> tenMatch_reg)
      else $error("ten-bit match not flagged");
   a_ack_done: assert property (evt.seqDone[C_ACKGO] && !ctrlWr |=> !ctl.reqGo[C_ACKGO])
      else $error("ack request not cleared");
   a_rcv_done: assert property (evt.seqDone[C_RXGO] && !ctrlWr |=> !ctl.reqGo[C_RXGO])
      else $error("receive request not cleared");
   a_mtx_begin: assert property (evt.mtxBegin |=> master_tx_active_reg)
      else $error("transmit status not set");
   a_stop_cond: assert property (evt.stopSeen && !evt.startSeen
                                 |=> stop_reg && !start_reg)
      else $error("stop flag wrong");
   a_data_flag: assert property (evt.rxValid && !evt.rxIsAddr && !matchAck |=> da_reg)
      else $error("data flag not set");

endmodule : twcs_ctrl_status

// [hdl/twcs_pkg.sv]
// constants and carrier types for the two-wire control and status block
package twcs_pkg;

   // --------------------------------------------------------------------
   // register byte offsets on the apb bus
   // --------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] TXD_OFS = 8'h08;
   localparam logic [7:0] RXD_OFS = 8'h0c;
   localparam logic [7:0] SADDR_OFS = 8'h10;
   localparam logic [7:0] BAUD_OFS = 8'h14;

   // --------------------------------------------------------------------
   // bus_control field positions
   // --------------------------------------------------------------------
   localparam int C_EN = 15;
   localparam int C_SIDL = 13;
   localparam int C_CLKREL = 12;
   localparam int C_IPMI = 11;
   localparam int C_TENBIT = 10;
   localparam int C_SLEW = 9;
   localparam int C_SMB = 8;
   localparam int C_GENCALL = 7;
   localparam int C_STRETCH = 6;
   localparam int C_ACKVAL = 5;
   localparam int C_ACKGO = 4;
   localparam int C_RXGO = 3;
   localparam int C_STOPGO = 2;
   localparam int C_RESTART = 1;
   localparam int C_STARTGO = 0;
   localparam int C_REQ_N = 5;
   localparam logic [15:0] CTRL_RST = 16'h1000;
   localparam logic [15:0] CTRL_MASK = 16'hbfff;

   // --------------------------------------------------------------------
   // bus_status field positions
   // --------------------------------------------------------------------
   localparam int S_ACKRX = 15;
   localparam int S_MTXACT = 14;
   localparam int S_BUSCOL = 10;
   localparam int S_GCSEEN = 9;
   localparam int S_TENMATCH = 8;
   localparam int S_WRCOL = 7;
   localparam int S_OV = 6;
   localparam int S_DA = 5;
   localparam int S_STOP = 4;
   localparam int S_START = 3;
   localparam int S_RW = 2;
   localparam int S_RXFULL = 1;
   localparam int S_TXFULL = 0;

   // --------------------------------------------------------------------
   // address matching constants
   // --------------------------------------------------------------------
   localparam logic [7:0] GC_ADDR = 8'h00;
   localparam logic [4:0] TENBIT_HDR = 5'h1e;

   // events reported by the serial engine, each a one-cycle pulse except busy/idleMode
   typedef struct packed {
      logic startSeen;
      logic stopSeen;
      logic rxValid;
      logic rxIsAddr;
      logic addrFirst;
      logic addrSecond;
      logic mtxBegin;
      logic ackDone;
      logic ackBit;
      logic collision;
      logic slvTxBegin;
      logic slvRxEnd;
      logic txDone;
      logic [C_REQ_N-1:0] seqDone;
      logic busy;
      logic idleMode;
   } twcs_evt_t;

   // settings handed to the serial engine and pin mux
   typedef struct packed {
      logic pinsOwned;
      logic run;
      logic holdClockLow;
      logic slewOff;
      logic smbusLevels;
      logic ackValue;
      logic [C_REQ_N-1:0] reqGo;
   } twcs_ctl_t;

endpackage : twcs_pkg

// [verification/tb_twcs_ctrl_status.sv]
// self-checking bench for the two-wire control and status register block
`timescale 1ns/10ps
module tb_twcs_ctrl_status;
   import twcs_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, txFull, addrAck, genCallIrq, rxIrq;
   twcs_evt_t evt;
   twcs_ctl_t ctl;
   logic [7:0] rxByte, txData;
   logic [15:0] baudReload;
   logic [9:0] slaveAddr;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   int nRx = 0;
   int nAck = 0;
   int nGc = 0;
   int k;
   // ---------------------------------------------------------------
   // clock, pulse counters and hang guard
   // ---------------------------------------------------------------
   initial begin
      forever #4 clk = ~clk;
   end
   // one-cycle pulses are counted so checks need not hit the exact cycle
   always @(posedge clk) begin
      nRx += (rxIrq === 1'b1);
      nAck += (addrAck === 1'b1);
      nGc += (genCallIrq === 1'b1);
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   twcs_ctrl_status #(.BAUD_W(16)) i_twcs_ctrl_status (.clk(clk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt), .rxByte(rxByte),
      .ctl(ctl), .txData(txData), .txFull(txFull), .baudReload(baudReload),
      .slaveAddr(slaveAddr), .addrAck(addrAck), .genCallIrq(genCallIrq), .rxIrq(rxIrq));
   twcs_engine_model i_twcs_engine_model (.clk(clk), .evt(evt), .rxByte(rxByte));
   // ---------------------------------------------------------------
   // apb master and compare helpers
   // ---------------------------------------------------------------
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic se);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task cv(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : cv
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic se;
      apb(1'b1, a, d, q, se);
   endtask : wr
   // read a register and compare the masked bits
   task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      logic se;
      apb(1'b0, a, 32'h0, q, se);
      cv($sformatf("reg %h", a), e, q & m);
   endtask : rc
   function automatic logic [31:0] b_(input int n);
      return 32'h1 << n;
   endfunction : b_
   task ev(input twcs_evt_t e, input logic [7:0] b);
      i_twcs_engine_model.pulse(e, b);
   endtask : ev
   task wrap_up();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic se;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      rc(CTRL_OFS, 32'hffffffff, 32'h1000);
      rc(STAT_OFS, 32'hffffffff, 32'h0);
      $display("test reset done");
      wr(CTRL_OFS, 32'hffff);
      rc(CTRL_OFS, 32'hffffffff, 32'(CTRL_MASK));
      cv("pins", 1, ctl.pinsOwned);
      cv("reqGo", 5'h1f, ctl.reqGo);
      cv("ctl", 11'h6ff, ctl);
      // each done pulse must clear only its own request
      for (int i = 0; i < 5; i++) begin
         ev('{seqDone: 5'(1 << i), default: '0}, 8'h00);
         rc(CTRL_OFS, 32'h1f, (32'h1f << (i + 1)) & 32'h1f);
      end
      wr(CTRL_OFS, 32'h9000);
      wr(CTRL_OFS, 32'h8000);
      rc(CTRL_OFS, 32'hffff, 32'h9000);
      ev('{slvRxEnd: 1'b1, default: '0}, 8'h00);
      rc(CTRL_OFS, 32'hffff, 32'h9000);
      ev('{slvTxBegin: 1'b1, default: '0}, 8'h00);
      rc(CTRL_OFS, 32'hffff, 32'h8000);
      cv("hold", 1, ctl.holdClockLow);
      wr(CTRL_OFS, 32'h9040);
      wr(CTRL_OFS, 32'h8040);
      rc(CTRL_OFS, 32'hffff, 32'h8040);
      wr(CTRL_OFS, 32'h9040);
      ev('{slvRxEnd: 1'b1, default: '0}, 8'h00);
      rc(CTRL_OFS, 32'hffff, 32'h8040);
      $display("test control done");
      wr(CTRL_OFS, 32'hb000);
      i_twcs_engine_model.set_levels(1'b0, 1'b1);
      repeat (3) @(posedge clk);
      cv("run idle", 0, ctl.run);
      wr(CTRL_OFS, 32'h9000);
      repeat (3) @(posedge clk);
      cv("run keep", 1, ctl.run);
      i_twcs_engine_model.set_levels(1'b0, 1'b0);
      $display("test idle done");
      ev('{rxValid: 1'b1, default: '0}, 8'h5a);
      rc(STAT_OFS, b_(S_RXFULL), b_(S_RXFULL));
      cv("rxIrq", 1, nRx);
      rc(RXD_OFS, 32'hff, 32'h5a);
      rc(STAT_OFS, b_(S_RXFULL), 32'h0);
      ev('{rxValid: 1'b1, default: '0}, 8'h11);
      ev('{rxValid: 1'b1, default: '0}, 8'h22);
      rc(STAT_OFS, b_(S_OV) | b_(S_RXFULL), b_(S_OV) | b_(S_RXFULL));
      cv("rxIrq", 2, nRx);
      rc(RXD_OFS, 32'hff, 32'h11);
      $display("test receive done");
      i_twcs_engine_model.set_levels(1'b1, 1'b0);
      wr(TXD_OFS, 32'h33);
      rc(STAT_OFS, b_(S_WRCOL) | b_(S_TXFULL), b_(S_WRCOL));
      i_twcs_engine_model.set_levels(1'b0, 1'b0);
      wr(TXD_OFS, 32'h44);
      rc(STAT_OFS, b_(S_TXFULL), b_(S_TXFULL));
      cv("txData", 8'h44, txData);
      ev('{txDone: 1'b1, default: '0}, 8'h00);
      rc(STAT_OFS, b_(S_TXFULL), 32'h0);
      cv("txFull", 0, txFull);
      ev('{collision: 1'b1, default: '0}, 8'h00);
      wr(STAT_OFS, 32'hffff);
      rc(STAT_OFS, 32'h4c0, 32'h4c0);
      wr(STAT_OFS, 32'h0);
      rc(STAT_OFS, 32'h4c0, 32'h0);
      $display("test flags done");
      ev('{startSeen: 1'b1, default: '0}, 8'h00);
      rc(STAT_OFS, 32'h18, b_(S_START));
      ev('{stopSeen: 1'b1, default: '0}, 8'h00);
      rc(STAT_OFS, 32'h18, b_(S_STOP));
      ev('{mtxBegin: 1'b1, default: '0}, 8'h00);
      rc(STAT_OFS, 32'hc000, b_(S_MTXACT));
      ev('{ackDone: 1'b1, ackBit: 1'b1, default: '0}, 8'h00);
      rc(STAT_OFS, 32'hc000, b_(S_ACKRX));
      ev('{ackDone: 1'b1, default: '0}, 8'h00);
      rc(STAT_OFS, 32'hc000, 32'h0);
      $display("test master done");
      wr(SADDR_OFS, 32'h2a);
      wr(CTRL_OFS, 32'h9080);
      ev('{addrFirst: 1'b1, default: '0}, 8'h55);
      rc(STAT_OFS, 32'h24, b_(S_RW));
      cv("addrAck", 1, nAck);
      ev('{rxValid: 1'b1, default: '0}, 8'h10);
      rc(STAT_OFS, 32'h20, b_(S_DA));
      ev('{addrFirst: 1'b1, default: '0}, GC_ADDR);
      rc(STAT_OFS, b_(S_GCSEEN), b_(S_GCSEEN));
      cv("gcIrq", 1, nGc);
      ev('{stopSeen: 1'b1, default: '0}, 8'h00);
      rc(STAT_OFS, b_(S_GCSEEN), 32'h0);
      wr(CTRL_OFS, 32'h9800);
      ev('{addrFirst: 1'b1, default: '0}, GC_ADDR);
      // the pulse comes one edge after the event and is counted one edge later
      repeat (2) @(posedge clk);
      cv("gcIrq", 1, nGc);
      k = nAck;
      ev('{addrFirst: 1'b1, default: '0}, 8'h77);
      repeat (2) @(posedge clk);
      cv("addrAck", k + 1, nAck);
      wr(SADDR_OFS, 32'h2b5);
      wr(CTRL_OFS, 32'h9400);
      cv("slaveAddr", 10'h2b5, slaveAddr);
      ev('{addrFirst: 1'b1, default: '0}, {TENBIT_HDR, 2'b10, 1'b0});
      ev('{addrSecond: 1'b1, default: '0}, 8'hb5);
      rc(STAT_OFS, b_(S_TENMATCH), b_(S_TENMATCH));
      ev('{stopSeen: 1'b1, default: '0}, 8'h00);
      rc(STAT_OFS, b_(S_TENMATCH), 32'h0);
      $display("test slave done");
      wr(BAUD_OFS, 32'h1234);
      // the write lands at the edge the task returns on, so look one edge later
      @(posedge clk);
      cv("baud", 16'h1234, baudReload);
      apb(1'b0, 8'h18, 32'h0, q, se);
      cv("unmapped", 1, se);
      cv("unmapped data", 0, q);
      wr(CTRL_OFS, 32'h0);
      @(posedge clk);
      cv("pins", 0, ctl.pinsOwned);
      $display("test misc done");
      wrap_up();
   end
endmodule : tb_twcs_ctrl_status

// [verification/twcs_engine_model.sv]
// behavioural model of the serial engine feeding events into the register block
`timescale 1ns/10ps
module twcs_engine_model (
   // clock
   input wire logic clk,
   // engine events and shifter byte
   output twcs_pkg::twcs_evt_t evt,
   output logic [7:0] rxByte
);
   import twcs_pkg::*;
   logic busyLvl = 1'b0;
   logic idleLvl = 1'b0;
   initial begin
      evt = '0;
      rxByte = 8'h00;
   end
   // levels change only on a clock edge, like the real engine state
   task set_levels(input logic b, input logic i);
      @(posedge clk);
      busyLvl = b;
      idleLvl = i;
      evt.busy <= b;
      evt.idleMode <= i;
   endtask : set_levels
   // one-cycle pulse; afterwards the shifter shows the inverse so stale reads show up
   task pulse(input twcs_evt_t e, input logic [7:0] b);
      twcs_evt_t v;
      v = e;
      v.busy = busyLvl;
      v.idleMode = idleLvl;
      @(posedge clk);
      evt <= v;
      rxByte <= b;
      v = '0;
      v.busy = busyLvl;
      v.idleMode = idleLvl;
      @(posedge clk);
      evt <= v;
      rxByte <= ~b;
   endtask : pulse
endmodule : twcs_engine_model
